// file: common/pml_defines.svh
/*
 * constants of the modulation limiter: register address, field positions,
 * reset value, nominal duty and bound offsets.
 * assumes: duty is counted in 1/256 of the switching period (256 = 100%).
 */
`ifndef PML_DEFINES_SVH
`define PML_DEFINES_SVH

// register address and layout
`define PML_CFG_ADDR 8'h2E
`define PML_CFG_RESET 8'h00
`define PML_CFG_WMASK 8'hF7
`define PML_BIT_BRIDGE 7
`define PML_HI_MSB 6
`define PML_HI_LSB 4
`define PML_BIT_SKIP 2
`define PML_LO_MSB 1
`define PML_LO_LSB 0

// duty scale: nominal duty is half the period
`define PML_NOMINAL 9'h080
`define PML_DUTY_ZERO 9'h000

// upper offsets, 1/256 period: 12.5 25 31.25 37.5 43.75 46.88 48.44 50 %
`define PML_HI_OFS_0 9'h020
`define PML_HI_OFS_1 9'h040
`define PML_HI_OFS_2 9'h050
`define PML_HI_OFS_3 9'h060
`define PML_HI_OFS_4 9'h070
`define PML_HI_OFS_5 9'h078
`define PML_HI_OFS_6 9'h07C
`define PML_HI_OFS_7 9'h080

// lower offsets, 1/256 period: 50 48.44 46.88 43.75 %
`define PML_LO_OFS_0 9'h080
`define PML_LO_OFS_1 9'h07C
`define PML_LO_OFS_2 9'h078
`define PML_LO_OFS_3 9'h070

`endif

// file: common/pml_pkg.sv
/*
 * types of the modulation limiter.
 * assumes: included constants live in pml_defines.svh.
 */
package pml_pkg;

    typedef logic [8:0] pml_duty_type;
    typedef logic [7:0] pml_byte_type;

    typedef enum logic {
        PML_SINGLE,
        PML_BRIDGE
    } pml_mode_type;

endpackage

// file: hdl/pml_bounds.sv
/*
 * upper and lower duty bounds from the limit codes and the bridge mode.
 * assumes: combinational leaf, codes come from the config register.
 */
`timescale 1ns/10ps
`default_nettype none
`include "pml_defines.svh"

module pml_bounds
    import pml_pkg::*;
(
    input wire logic [2:0] hi_code_i,
    input wire logic [1:0] lo_code_i,
    input wire pml_mode_type mode_i,
    output pml_duty_type hi_bound_o,
    output pml_duty_type lo_bound_o
);

    ////////////////////////////////////////////////////////////////////////
    // offset tables

    function automatic pml_duty_type hi_offset(input logic [2:0] code);
        unique case (code)
            3'h0: hi_offset = `PML_HI_OFS_0;
            3'h1: hi_offset = `PML_HI_OFS_1;
            3'h2: hi_offset = `PML_HI_OFS_2;
            3'h3: hi_offset = `PML_HI_OFS_3;
            3'h4: hi_offset = `PML_HI_OFS_4;
            3'h5: hi_offset = `PML_HI_OFS_5;
            3'h6: hi_offset = `PML_HI_OFS_6;
            3'h7: hi_offset = `PML_HI_OFS_7;
        endcase
    endfunction

    function automatic pml_duty_type lo_offset(input logic [1:0] code);
        unique case (code)
            2'h0: lo_offset = `PML_LO_OFS_0;
            2'h1: lo_offset = `PML_LO_OFS_1;
            2'h2: lo_offset = `PML_LO_OFS_2;
            2'h3: lo_offset = `PML_LO_OFS_3;
        endcase
    endfunction

    function automatic pml_duty_type scale(input pml_duty_type ofs,
                                           input pml_mode_type mode);
        scale = (mode == PML_BRIDGE) ? (ofs >> 1) : ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bounds

    always_comb begin
        hi_bound_o = `PML_NOMINAL + scale(hi_offset(hi_code_i), mode_i);
        lo_bound_o = `PML_NOMINAL - scale(lo_offset(lo_code_i), mode_i);
    end

endmodule
`default_nettype wire

// file: hdl/pml_limiter.sv
/*
 * modulation limiter: config register plus per-channel duty clamping,
 * bridge sharing and pulse skipping.
 * assumes: register port and duty input come from logic on mclk_i;
 * duty_i is in 1/256 of the period, at most 256.
 */
//
// Overview of operation
// - bit 7 selects full-bridge bound handling
// - bridge splits duty over two outputs, A taking the extra count when odd
// - bridge halves every upper and lower bound offset from nominal
// - bits 6:4 pick upper bound above nominal
// - bits 1:0 pick lower bound below nominal
// - bit 2 enables pulse skipping mode
// - skipping drops pulses below lower bound
`timescale 1ns/10ps
`default_nettype none
`include "pml_defines.svh"

module pml_limiter
    import pml_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_ack_o,
    input wire logic [8:0] duty_i,
    input wire logic duty_valid_i,
    output logic [8:0] duty_a_o,
    output logic [8:0] duty_b_o,
    output logic skip_a_o,
    output logic skip_b_o,
    output logic clamped_o,
    output logic duty_valid_o,
    output logic bridge_o
);

    ////////////////////////////////////////////////////////////////////////
    // config register

    pml_byte_type cfg_d;
    pml_byte_type cfg_q;
    pml_byte_type rdata_d;
    pml_byte_type rdata_q;
    logic ack_d;
    logic ack_q;
    logic hit;

    always_comb begin
        hit = (reg_addr_i == `PML_CFG_ADDR);
        cfg_d = cfg_q;
        if (reg_wr_i && hit) begin
            cfg_d = reg_wdata_i & `PML_CFG_WMASK;
        end
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            rdata_d = hit ? cfg_q : 8'h00;
        end
        ack_d = reg_rd_i | reg_wr_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_q <= `PML_CFG_RESET;
            rdata_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // field decode and bounds

    pml_mode_type mode;
    logic skip_en;
    pml_duty_type hi_bound;
    pml_duty_type lo_bound;

    always_comb begin
        mode = cfg_q[`PML_BIT_BRIDGE] ? PML_BRIDGE : PML_SINGLE;
        skip_en = cfg_q[`PML_BIT_SKIP];
    end

    pml_bounds u_bounds (
        .hi_code_i(cfg_q[`PML_HI_MSB:`PML_HI_LSB]),
        .lo_code_i(cfg_q[`PML_LO_MSB:`PML_LO_LSB]),
        .mode_i(mode),
        .hi_bound_o(hi_bound),
        .lo_bound_o(lo_bound)
    );

    ////////////////////////////////////////////////////////////////////////
    // demand per channel

    pml_duty_type demand [2];
    logic active [2];

    always_comb begin
        unique case (mode)
            PML_BRIDGE: begin
                demand[0] = pml_duty_type'((10'(duty_i) + 10'h001) >> 1);
                demand[1] = duty_i >> 1;
                active[0] = 1'b1;
                active[1] = 1'b1;
            end
            PML_SINGLE: begin
                demand[0] = duty_i;
                demand[1] = `PML_DUTY_ZERO;
                active[0] = 1'b1;
                active[1] = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // per-channel limiting

    typedef struct packed {
        logic [8:0] duty;
        logic skip;
        logic clamp;
    } pml_lim_type;

    function automatic pml_lim_type limit(input pml_duty_type want,
                                          input pml_duty_type lo,
                                          input pml_duty_type hi,
                                          input logic skip_on);
        pml_lim_type res;
        res.duty = want;
        res.skip = 1'b0;
        res.clamp = 1'b0;
        if (want < lo) begin
            if (skip_on) begin
                res.duty = `PML_DUTY_ZERO;
                res.skip = 1'b1;
            end else begin
                res.duty = lo;
                res.clamp = 1'b1;
            end
        end else if (want > hi) begin
            res.duty = hi;
            res.clamp = 1'b1;
        end
        limit = res;
    endfunction

    pml_duty_type chan_duty_d [2];
    pml_duty_type chan_duty_q [2];
    logic chan_skip_d [2];
    logic chan_skip_q [2];
    logic chan_clamp_d [2];
    logic chan_clamp_q [2];

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            pml_lim_type lim;

            always_comb begin
                lim = limit(demand[ch], lo_bound, hi_bound, skip_en);
                chan_duty_d[ch] = chan_duty_q[ch];
                chan_skip_d[ch] = chan_skip_q[ch];
                chan_clamp_d[ch] = chan_clamp_q[ch];
                if (duty_valid_i) begin
                    if (active[ch]) begin
                        chan_duty_d[ch] = lim.duty;
                        chan_skip_d[ch] = lim.skip;
                        chan_clamp_d[ch] = lim.clamp;
                    end else begin
                        chan_duty_d[ch] = `PML_DUTY_ZERO;
                        chan_skip_d[ch] = 1'b0;
                        chan_clamp_d[ch] = 1'b0;
                    end
                end
            end

            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    chan_duty_q[ch] <= `PML_DUTY_ZERO;
                    chan_skip_q[ch] <= 1'b0;
                    chan_clamp_q[ch] <= 1'b0;
                end else begin
                    chan_duty_q[ch] <= chan_duty_d[ch];
                    chan_skip_q[ch] <= chan_skip_d[ch];
                    chan_clamp_q[ch] <= chan_clamp_d[ch];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // output strobe and mode

    logic valid_d;
    logic valid_q;
    logic bridge_d;
    logic bridge_q;

    always_comb begin
        valid_d = duty_valid_i;
        bridge_d = bridge_q;
        if (duty_valid_i) begin
            bridge_d = (mode == PML_BRIDGE);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            valid_q <= 1'b0;
            bridge_q <= 1'b0;
        end else begin
            valid_q <= valid_d;
            bridge_q <= bridge_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata_o = rdata_q;
    assign reg_ack_o = ack_q;
    assign duty_a_o = chan_duty_q[0];
    assign duty_b_o = chan_duty_q[1];
    assign skip_a_o = chan_skip_q[0];
    assign skip_b_o = chan_skip_q[1];
    assign clamped_o = chan_clamp_q[0] | chan_clamp_q[1];
    assign duty_valid_o = valid_q;
    assign bridge_o = bridge_q;

endmodule
`default_nettype wire

// file: verification/pml_limiter_asserts.sv
/* port checker of the modulation limiter.
   assumes: bound to pml_limiter, one clock, async reset high. */
`timescale 1ns/10ps
`default_nettype none
module pml_limiter_asserts (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    input wire logic [8:0] duty_i,
    input wire logic duty_valid_i,
    input wire logic [8:0] duty_a_o,
    input wire logic [8:0] duty_b_o,
    input wire logic skip_a_o,
    input wire logic skip_b_o,
    input wire logic clamped_o,
    input wire logic duty_valid_o,
    input wire logic bridge_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    AST_ACK: assert property ((reg_wr_i || reg_rd_i) |=> reg_ack_o)
        else $error("no ack after strobe");
    AST_RSVD: assert property (reg_rd_i |=> !reg_rdata_o[3])
        else $error("reserved bit read as one");
    AST_RHOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    AST_UNMAP: assert property (reg_rd_i && reg_addr_i != 8'h2E
        |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_VALID: assert property (duty_valid_i |=> duty_valid_o)
        else $error("duty result late");
    AST_SINGLE: assert property (duty_valid_o && !bridge_o
        |-> duty_b_o == 9'h000 && !skip_b_o) else $error("b busy in single");
    AST_SPLIT: assert property (duty_valid_o && bridge_o && !clamped_o
        && !skip_a_o && !skip_b_o |-> duty_a_o - duty_b_o <= 9'h001)
        else $error("bridge halves unequal");
    AST_SKIP: assert property (duty_valid_o && skip_a_o
        |-> duty_a_o == 9'h000) else $error("skipped pulse not zero");
    AST_PASS: assert property (duty_valid_i && duty_i inside {[16:160]}
        ##1 !bridge_o |-> duty_a_o == $past(duty_i) && !clamped_o)
        else $error("in-range duty altered");
    AST_BPASS: assert property (duty_valid_i && duty_i inside {[144:256]}
        ##1 bridge_o |-> duty_a_o == ($past(duty_i) + 9'h001) >> 1)
        else $error("bridge in-range duty altered");
    COV_CLAMP: cover property (duty_valid_o && clamped_o);
    COV_SKIP: cover property (duty_valid_o && skip_b_o);
    COV_BRIDGE: cover property (duty_valid_o && bridge_o);
endmodule
bind pml_limiter pml_limiter_asserts pml_limiter_asserts_inst (.mclk_i,
    .rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_ack_o,
    .duty_i, .duty_valid_i, .duty_a_o, .duty_b_o, .skip_a_o, .skip_b_o,
    .clamped_o, .duty_valid_o, .bridge_o);
`default_nettype wire

// file: verification/pml_stage_model.sv
/* power stage model: counts the pulses it is told to omit.
   assumes: fed by the limiter outputs on mclk_i. */
`timescale 1ns/10ps
`default_nettype none
module pml_stage_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic duty_valid_i,
    input wire logic skip_a_i,
    input wire logic skip_b_i,
    output logic [7:0] skips_o
);
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            skips_o <= 8'h00;
        end else if (duty_valid_i) begin
            skips_o <= skips_o + 8'(skip_a_i) + 8'(skip_b_i);
        end
    end
endmodule
`default_nettype wire

// file: verification/testbench.sv
/* self-checking bench of the modulation limiter.
   assumes: design, checker and stage model compiled first. */
`timescale 1ns/10ps
`default_nettype none
`include "pml_defines.svh"
module testbench
    import pml_pkg::*;
;
    logic mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic duty_valid_i = 1'b0, reg_ack_o, skip_a_o, skip_b_o, clamped_o;
    logic duty_valid_o, bridge_o;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, cfg = 8'h00;
    logic [7:0] reg_rdata_o, skips, n_skip = 8'h00;
    logic [8:0] duty_i = 9'h000, duty_a_o, duty_b_o;
    logic [8:0] hofs [8] = '{`PML_HI_OFS_0, `PML_HI_OFS_1, `PML_HI_OFS_2,
        `PML_HI_OFS_3, `PML_HI_OFS_4, `PML_HI_OFS_5, `PML_HI_OFS_6,
        `PML_HI_OFS_7};
    logic [8:0] lofs [4] = '{`PML_LO_OFS_0, `PML_LO_OFS_1, `PML_LO_OFS_2,
        `PML_LO_OFS_3};
    int n_fail = 0, tests_run = 0;
    always #20 mclk_i = ~mclk_i;
    pml_limiter pml_limiter_inst (.mclk_i, .rst_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .duty_i,
        .duty_valid_i, .duty_a_o, .duty_b_o, .skip_a_o, .skip_b_o,
        .clamped_o, .duty_valid_o, .bridge_o);
    pml_stage_model pml_stage_model_inst (.mclk_i, .rst_i,
        .duty_valid_i(duty_valid_o), .skip_a_i(skip_a_o),
        .skip_b_i(skip_b_o), .skips_o(skips));
    task automatic end_of_test;
        $display("compared %0d, bad %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t byte %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_duty(input logic [8:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t duty %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t flag %b exp %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge mclk_i);
        #1 reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(posedge mclk_i);
        #1 reg_wr_i = 1'b0;
        if (a == `PML_CFG_ADDR) cfg = d & `PML_CFG_WMASK;
        cmp_flag(reg_ack_o, 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge mclk_i);
        #1 reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(posedge mclk_i);
        #1 reg_rd_i = 1'b0;
        cmp_byte(reg_rdata_o, e);
    endtask
    task automatic samp(input logic [8:0] d);
        logic [8:0] h, l;
        logic [8:0] x [2];
        logic [1:0] sk;
        logic cl, br;
        br = cfg[7];
        h = `PML_NOMINAL + (hofs[cfg[6:4]] >> br);
        l = `PML_NOMINAL - (lofs[cfg[1:0]] >> br);
        x[0] = br ? (d + 9'h001) >> 1 : d;
        x[1] = br ? d >> 1 : 9'h000;
        sk = 2'b00;
        cl = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if ((i == 0 || br) && x[i] < l && cfg[2]) begin
                x[i] = 9'h000;
                sk[i] = 1'b1;
            end else if ((i == 0 || br) && x[i] < l) begin
                x[i] = l;
                cl = 1'b1;
            end else if ((i == 0 || br) && x[i] > h) begin
                x[i] = h;
                cl = 1'b1;
            end
        end
        n_skip = n_skip + 8'(sk[0]) + 8'(sk[1]);
        @(posedge mclk_i);
        #1 duty_i = d;
        duty_valid_i = 1'b1;
        @(posedge mclk_i);
        #1 duty_valid_i = 1'b0;
        cmp_flag(duty_valid_o, 1'b1);
        cmp_duty(duty_a_o, x[0]);
        cmp_duty(duty_b_o, x[1]);
        cmp_flag(skip_a_o, sk[0]);
        cmp_flag(skip_b_o, sk[1]);
        cmp_flag(clamped_o, cl);
        cmp_flag(bridge_o, br);
    endtask
    task automatic t_reg;
        rd(8'h2E, 8'h00);
        wr(8'h2E, 8'hFF);
        rd(8'h2E, 8'hF7);
        wr(8'h2D, 8'h55);
        rd(8'h2D, 8'h00);
        rd(8'h2E, 8'hF7);
    endtask
    task automatic t_hi;
        for (int c = 0; c < 8; c++) begin
            wr(8'h2E, {1'b0, 3'(c), 4'h0});
            samp(9'h100);
            samp(9'h0A0);
        end
    endtask
    task automatic t_lo;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                wr(8'h2E, {5'h00, 1'(s), 2'(c)});
                samp(9'h000);
                samp(9'h00F);
            end
        end
    endtask
    task automatic t_br;
        for (int s = 0; s < 2; s++) begin
            for (int c = 0; c < 4; c++) begin
                wr(8'h2E, {1'b1, 3'(c), 1'b0, 1'(s), 2'(c)});
                samp(9'h001);
                samp(9'h0C9);
                samp(9'h08F);
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge mclk_i);
        #1 rst_i = 1'b0;
        t_reg;
        t_hi;
        t_lo;
        t_br;
        @(posedge mclk_i);
        #1 cmp_byte(skips, n_skip);
        end_of_test;
    end
    initial begin
        #400000;
        n_fail++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test;
    end
endmodule
`default_nettype wire
